/* core/dsf_defines.vh */
// constants for the driver status flag register bank
`ifndef DSF_DEFINES_VH
`define DSF_DEFINES_VH

// register byte offsets on the apb bus
`define DSF_AW 12
`define DSF_ADDR_STATUS 12'h000
`define DSF_ADDR_CTRL 12'h004
`define DSF_ADDR_IRQ_STATUS 12'h008
`define DSF_ADDR_IRQ_MASK 12'h00C

// driver status snapshot fields
`define DSF_ST_STANDSTILL 31
`define DSF_ST_OPEN_B 30
`define DSF_ST_OPEN_A 29
`define DSF_ST_GSHORT_B 28
`define DSF_ST_GSHORT_A 27
`define DSF_ST_OT_PREWARN 26
`define DSF_ST_OT_SHUTDOWN 25
`define DSF_ST_STALL 24
`define DSF_ST_CS_HI 20
`define DSF_ST_CS_LO 16
`define DSF_ST_LOAD_HI 9
`define DSF_ST_LOAD_LO 0
`define DSF_CS_W 5
`define DSF_LOAD_W 10
`define DSF_LOAD_ZERO 10'h000

// control register
`define DSF_CHOPPER_OFF_TIME_HI 3
`define DSF_CHOPPER_OFF_TIME_LO 0
`define DSF_CHOPPER_OFF_TIME_W 4
`define DSF_CHOPPER_OFF_TIME_RESET 4'h0
`define DSF_CHOPPER_OFF_TIME_OFF 4'h0

// interrupt status and mask layout
`define DSF_IRQ_W 8
`define DSF_IRQ_RESET 8'h00

// synchronised pin vector layout
`define DSF_PIN_W 8
`define DSF_PIN_STEP 0
`define DSF_PIN_OPEN_A 1
`define DSF_PIN_OPEN_B 2
`define DSF_PIN_GSHORT_A 3
`define DSF_PIN_GSHORT_B 4
`define DSF_PIN_PREWARN 5
`define DSF_PIN_OT_LIMIT 6
`define DSF_PIN_BRIDGE_N 7

// standstill delay after the last step pulse
`define DSF_STST_W 21
`define DSF_STST_CLOCKS 21'h100000
`define DSF_STST_ZERO 21'h000000
`define DSF_STST_ONE 21'h000001

`define DSF_WORD_ZERO 32'h00000000

`endif

/* core/dsf_sync2.v */
// two flip-flop synchroniser, one chain per bit
`timescale 1ns/1ps
`default_nettype none
module dsf_sync2 #(
    parameter WIDTH = 8
) (
    input wire pclk,
    input wire presetn,
    input wire ce,
    input wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            reg stage1;
            reg stage2;
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    stage1 <= 1'b0;
                    stage2 <= 1'b0;
                end else if (ce) begin
                    stage1 <= async_in[i];
                    stage2 <= stage1;
                end
            end
            assign sync_out[i] = stage2;
        end
    endgenerate
endmodule // dsf_sync2
`default_nettype wire

/* core/dsf_standstill.v */
// standstill detector: counts clocks since the last step pulse
`timescale 1ns/1ps
`include "dsf_defines.vh"
`default_nettype none
module dsf_standstill #(
    parameter [`DSF_STST_W-1:0] STANDSTILL_CLOCKS = `DSF_STST_CLOCKS
) (
    input wire pclk,
    input wire presetn,
    input wire ce,
    input wire step_edge,
    output reg standstill
);
    reg [`DSF_STST_W-1:0] count;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= `DSF_STST_ZERO;
            standstill <= 1'b0;
        end else if (ce) begin
            if (step_edge) begin
                // stepping resumed
                count <= `DSF_STST_ZERO;
                standstill <= 1'b0;
            end else if (count != STANDSTILL_CLOCKS) begin
                count <= count + `DSF_STST_ONE;
                if (count == STANDSTILL_CLOCKS - `DSF_STST_ONE) begin
                    standstill <= 1'b1;
                end
            end
        end
    end
endmodule // dsf_standstill
`default_nettype wire

/* core/dsf_driver_status.v */
// driver status flag bank with apb slave and interrupt logic
//
// Contract
// - standstill set 2^20 clocks after last step
// - one open-load flag per phase
// - open-load flags never affect power stage
// - ground short sets phase flag, disables stage
// - ground short held until stage disabled
// - prewarning flag high above prewarning threshold
// - one shared prewarning and overtemperature flag
// - overtemperature sets flag, disables drivers
// - drivers stay off until prewarning clears
// - stall on zero load or speed-mode stall
// - report applied current scaling value
// - stall compares load result against zero
`timescale 1ns/1ps
`include "dsf_defines.vh"
`default_nettype none
module dsf_driver_status #(
    parameter [`DSF_STST_W-1:0] STANDSTILL_CLOCKS = `DSF_STST_CLOCKS
) (
    input wire pclk,
    input wire presetn,
    input wire ce,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`DSF_AW-1:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    output reg irq,
    input wire step_pulse,
    input wire open_load_a_det,
    input wire open_load_b_det,
    input wire ground_short_a_det,
    input wire ground_short_b_det,
    input wire temp_prewarn_det,
    input wire temp_limit_det,
    input wire bridge_enable_n,
    input wire [`DSF_LOAD_W-1:0] load_measurement_result,
    input wire load_speed_mode,
    input wire speed_stall_det,
    input wire [`DSF_CS_W-1:0] cs_actual,
    output reg power_stage_enable
);

    // pin synchronisation
    wire [`DSF_PIN_W-1:0] pins_raw;
    wire [`DSF_PIN_W-1:0] pins_s;

    assign pins_raw[`DSF_PIN_STEP] = step_pulse;
    assign pins_raw[`DSF_PIN_OPEN_A] = open_load_a_det;
    assign pins_raw[`DSF_PIN_OPEN_B] = open_load_b_det;
    assign pins_raw[`DSF_PIN_GSHORT_A] = ground_short_a_det;
    assign pins_raw[`DSF_PIN_GSHORT_B] = ground_short_b_det;
    assign pins_raw[`DSF_PIN_PREWARN] = temp_prewarn_det;
    assign pins_raw[`DSF_PIN_OT_LIMIT] = temp_limit_det;
    assign pins_raw[`DSF_PIN_BRIDGE_N] = bridge_enable_n;

    dsf_sync2 #(
        .WIDTH(`DSF_PIN_W)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .async_in(pins_raw),
        .sync_out(pins_s)
    );

    wire step_s = pins_s[`DSF_PIN_STEP];
    wire bridge_off_s = pins_s[`DSF_PIN_BRIDGE_N];
    wire prewarn_s = pins_s[`DSF_PIN_PREWARN];
    wire ot_limit_s = pins_s[`DSF_PIN_OT_LIMIT];

    // step edge detection on the synchronised level
    // resets to the idle pin level, so no false edge follows reset
    reg step_prev;
    wire step_edge = step_s & ~step_prev;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            step_prev <= 1'b0;
        end else if (ce) begin
            step_prev <= step_s;
        end
    end

    wire standstill;

    dsf_standstill #(
        .STANDSTILL_CLOCKS(STANDSTILL_CLOCKS)
    ) u_standstill (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .step_edge(step_edge),
        .standstill(standstill)
    );

    // software control
    reg [`DSF_CHOPPER_OFF_TIME_W-1:0] chopper_off_time;
    reg [`DSF_IRQ_W-1:0] irq_mask;
    reg [`DSF_IRQ_W-1:0] irq_status;

    // status flags
    reg open_load_a;
    reg open_load_b;
    reg ground_short_a;
    reg ground_short_b;
    reg overtemp_prewarn;
    reg overtemp_shutdown;
    reg stall_detected_flag;
    reg [`DSF_LOAD_W-1:0] load_result_q;
    reg [`DSF_CS_W-1:0] cs_actual_q;

    // stage is off by software or by the enable pin
    wire stage_off_req = (chopper_off_time == `DSF_CHOPPER_OFF_TIME_OFF) |
                         bridge_off_s;

    // detection sets, disabling clears; set wins
    wire next_ground_short_a = pins_s[`DSF_PIN_GSHORT_A] |
                               (ground_short_a & ~stage_off_req);
    wire next_ground_short_b = pins_s[`DSF_PIN_GSHORT_B] |
                               (ground_short_b & ~stage_off_req);

    // latched until both limit and prewarning are gone
    wire next_overtemp_shutdown = ot_limit_s |
                                  (overtemp_shutdown & prewarn_s);

    wire next_stall = (load_measurement_result == `DSF_LOAD_ZERO) |
                      (load_speed_mode & speed_stall_det);

    // open-load flags follow the detector level
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            open_load_a <= 1'b0;
            open_load_b <= 1'b0;
        end else if (ce) begin
            open_load_a <= pins_s[`DSF_PIN_OPEN_A];
            open_load_b <= pins_s[`DSF_PIN_OPEN_B];
        end
    end

    // one prewarning flag shared by both bridges
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overtemp_prewarn <= 1'b0;
        end else if (ce) begin
            overtemp_prewarn <= prewarn_s;
        end
    end

    // ground short flags stay set until the stage is disabled
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ground_short_a <= 1'b0;
            ground_short_b <= 1'b0;
        end else if (ce) begin
            ground_short_a <= next_ground_short_a;
            ground_short_b <= next_ground_short_b;
        end
    end

    // one overtemperature flag shared by both bridges
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overtemp_shutdown <= 1'b0;
        end else if (ce) begin
            overtemp_shutdown <= next_overtemp_shutdown;
        end
    end

    // stall flag registered from same-clock inputs
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stall_detected_flag <= 1'b0;
        end else if (ce) begin
            stall_detected_flag <= next_stall;
        end
    end

    // load result and current scaling captured for the status word
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            load_result_q <= `DSF_LOAD_ZERO;
            cs_actual_q <= {`DSF_CS_W{1'b0}};
        end else if (ce) begin
            load_result_q <= load_measurement_result;
            cs_actual_q <= cs_actual;
        end
    end

    // open-load flags take no part in the enable term
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_stage_enable <= 1'b0;
        end else if (ce) begin
            power_stage_enable <= ~stage_off_req &
                                  ~next_ground_short_a &
                                  ~next_ground_short_b &
                                  ~next_overtemp_shutdown;
        end
    end

    // status word assembly, reserved bits are zero
    reg [31:0] status_word;

    always @* begin
        status_word = `DSF_WORD_ZERO;
        status_word[`DSF_ST_STANDSTILL] = standstill;
        status_word[`DSF_ST_OPEN_B] = open_load_b;
        status_word[`DSF_ST_OPEN_A] = open_load_a;
        status_word[`DSF_ST_GSHORT_B] = ground_short_b;
        status_word[`DSF_ST_GSHORT_A] = ground_short_a;
        status_word[`DSF_ST_OT_PREWARN] = overtemp_prewarn;
        status_word[`DSF_ST_OT_SHUTDOWN] = overtemp_shutdown;
        status_word[`DSF_ST_STALL] = stall_detected_flag;
        status_word[`DSF_ST_CS_HI:`DSF_ST_CS_LO] = cs_actual_q;
        status_word[`DSF_ST_LOAD_HI:`DSF_ST_LOAD_LO] = load_result_q;
    end

    // interrupt events: rising edges of the flags
    wire [`DSF_IRQ_W-1:0] flags_now = {stall_detected_flag,
                                       overtemp_shutdown,
                                       overtemp_prewarn,
                                       ground_short_b,
                                       ground_short_a,
                                       open_load_b,
                                       open_load_a,
                                       standstill};
    reg [`DSF_IRQ_W-1:0] flags_prev;
    wire [`DSF_IRQ_W-1:0] irq_event = flags_now & ~flags_prev;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_prev <= `DSF_IRQ_RESET;
        end else if (ce) begin
            flags_prev <= flags_now;
        end
    end

    // apb decode
    wire access = psel & penable;
    wire xfer_done = access & pready;
    wire wr_done = xfer_done & pwrite;
    wire rd_done = xfer_done & ~pwrite;

    // unmapped offsets read zero and raise pslverr
    reg addr_hit;
    reg [31:0] read_mux;

    always @* begin
        addr_hit = 1'b1;
        read_mux = `DSF_WORD_ZERO;
        case (paddr)
            `DSF_ADDR_STATUS: begin
                read_mux = status_word;
            end
            `DSF_ADDR_CTRL: begin
                read_mux[`DSF_CHOPPER_OFF_TIME_HI:`DSF_CHOPPER_OFF_TIME_LO] = chopper_off_time;
            end
            `DSF_ADDR_IRQ_STATUS: begin
                read_mux[`DSF_IRQ_W-1:0] = irq_status;
            end
            `DSF_ADDR_IRQ_MASK: begin
                read_mux[`DSF_IRQ_W-1:0] = irq_mask;
            end
            default: begin
                addr_hit = 1'b0;
            end
        endcase
    end

    // one wait state, answer registered
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= `DSF_WORD_ZERO;
        end else if (ce) begin
            if (access & ~pready) begin
                pready <= 1'b1;
                pslverr <= ~addr_hit;
                prdata <= pwrite ? `DSF_WORD_ZERO : read_mux;
            end else begin
                pready <= 1'b0;
                pslverr <= 1'b0;
            end
        end
    end

    // writable registers; the status word ignores writes
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chopper_off_time <= `DSF_CHOPPER_OFF_TIME_RESET;
            irq_mask <= `DSF_IRQ_RESET;
        end else if (ce && wr_done) begin
            case (paddr)
                `DSF_ADDR_CTRL: begin
                    chopper_off_time <= pwdata[`DSF_CHOPPER_OFF_TIME_HI:`DSF_CHOPPER_OFF_TIME_LO];
                end
                `DSF_ADDR_IRQ_MASK: begin
                    irq_mask <= pwdata[`DSF_IRQ_W-1:0];
                end
                default: begin
                    // status word and unmapped: no effect
                    irq_mask <= irq_mask;
                end
            endcase
        end
    end

    // read-clear only removes the bits that were reported
    wire irq_rd_clear = rd_done & (paddr == `DSF_ADDR_IRQ_STATUS);
    wire [`DSF_IRQ_W-1:0] irq_clear = irq_rd_clear ?
                                      prdata[`DSF_IRQ_W-1:0] :
                                      `DSF_IRQ_RESET;
    wire [`DSF_IRQ_W-1:0] next_irq_status;

    genvar b;
    generate
        for (b = 0; b < `DSF_IRQ_W; b = b + 1) begin : g_irq
            // a new event wins over a clear in the same cycle
            assign next_irq_status[b] = irq_event[b] |
                                        (irq_status[b] & ~irq_clear[b]);
        end
    endgenerate

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // irq follows the next status, so it rises with the bit
            irq_status <= `DSF_IRQ_RESET;
            irq <= 1'b0;
        end else if (ce) begin
            irq_status <= next_irq_status;
            irq <= |(next_irq_status & irq_mask);
        end
    end

endmodule // dsf_driver_status
`default_nettype wire

/* tb/dsf_driver_status_properties.sv */
// concurrent checks on the driver status flag bank ports
`timescale 1ns/1ps
`default_nettype none
module dsf_driver_status_props #(
    parameter logic [20:0] STANDSTILL_CLOCKS = 21'h100000
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic power_stage_enable,
    input wire logic ground_short_a_det,
    input wire logic ground_short_b_det,
    input wire logic temp_prewarn_det,
    input wire logic temp_limit_det,
    input wire logic bridge_enable_n
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn || !ce);

    sequence s_access;
        psel && $rose(penable);
    endsequence
    // pin passes two sync flops and the enable flop before the stage drops
    sequence s_shut;
        ##[1:4] !power_stage_enable;
    endsequence

    AST_ONE_WAIT: assert property (s_access |-> !pready ##1 pready)
        else $error("apb answer not after one wait state");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    AST_ERR_WITH_READY: assert property (pslverr |-> pready)
        else $error("pslverr outside answer cycle");
    AST_SHORT_A_OFF: assert property ($rose(ground_short_a_det) |-> s_shut)
        else $error("stage not off after short on phase a");
    AST_SHORT_B_OFF: assert property ($rose(ground_short_b_det) |-> s_shut)
        else $error("stage not off after short on phase b");
    AST_OT_OFF: assert property ($rose(temp_limit_det) |-> s_shut)
        else $error("stage not off after overtemperature");
    AST_OT_HOLD: assert property (temp_limit_det ##1 temp_prewarn_det [*5]
        |-> !power_stage_enable)
        else $error("stage back on while prewarning high");
    AST_BRIDGE_OFF: assert property (bridge_enable_n [*4]
        |-> !power_stage_enable)
        else $error("stage on while bridge disabled");
endmodule // dsf_driver_status_props
`default_nettype wire

/* tb/dsf_driver_status_tb_top.sv */
// self-checking bench of the driver status flag bank
`timescale 1ns/1ps
`default_nettype none
`include "dsf_defines.vh"
`define CHK(got, exp) \
    begin \
        total_checks++; \
        if ((got) !== (exp)) begin \
            miscompares++; \
            $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp); \
        end \
    end
module dsf_driver_status_tb_top;
    logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000, prdata, rd, keep;
    logic pready, pslverr, irq, power_stage_enable, err;
    logic step_pulse = 0, open_load_a_det = 0, open_load_b_det = 0;
    logic ground_short_a_det = 0, ground_short_b_det = 0;
    logic temp_prewarn_det = 0, temp_limit_det = 0, bridge_enable_n = 0;
    logic [9:0] load_measurement_result = 10'h155;
    logic load_speed_mode = 0, speed_stall_det = 0;
    logic [4:0] cs_actual = 5'h00;
    int miscompares = 0, total_checks = 0;

    dsf_driver_status #(.STANDSTILL_CLOCKS(21'h000010)) dut_u (
        .pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .irq, .step_pulse, .open_load_a_det,
        .open_load_b_det, .ground_short_a_det, .ground_short_b_det,
        .temp_prewarn_det, .temp_limit_det, .bridge_enable_n,
        .load_measurement_result, .load_speed_mode, .speed_stall_det,
        .cs_actual, .power_stage_enable
    );

    always #25 pclk = ~pclk;

    task automatic tally_and_finish();
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            miscompares++;
            tally_and_finish();
        end
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask

    task automatic rdst();
        apb(0, `DSF_ADDR_STATUS, 32'h00000000);
    endtask

    task automatic t_reset();
        rdst();
        `CHK(rd, 32'h00000155)
        `CHK(power_stage_enable, 1'b0)
        apb(0, `DSF_ADDR_IRQ_MASK, 32'h00000000);
        `CHK(rd, 32'h00000000)
        apb(0, 12'h010, 32'h00000000);
        `CHK({err, rd}, 33'h100000000)
    endtask

    task automatic t_standstill();
        cyc(20);
        rdst();
        `CHK(rd[`DSF_ST_STANDSTILL], 1'b1)
        `CHK(irq, 1'b0)
        apb(1, `DSF_ADDR_IRQ_MASK, 32'h00000001);
        cyc(2);
        `CHK(irq, 1'b1)
        apb(0, `DSF_ADDR_IRQ_STATUS, 32'h00000000);
        `CHK(rd[0], 1'b1)
        cyc(2);
        `CHK(irq, 1'b0)
        step_pulse <= 1;
        cyc(3);
        step_pulse <= 0;
        cyc(3);
        rdst();
        `CHK(rd[`DSF_ST_STANDSTILL], 1'b0)
        cyc(20);
        `CHK(irq, 1'b1)
        apb(1, `DSF_ADDR_IRQ_MASK, 32'h00000000);
        cyc(2);
        `CHK(irq, 1'b0)
    endtask

    task automatic t_short();
        for (int i = 0; i < 2; i++) begin
            apb(1, `DSF_ADDR_CTRL, 32'h00000005);
            bridge_enable_n <= 0;
            cyc(6);
            `CHK(power_stage_enable, 1'b1)
            if (i == 0) ground_short_a_det <= 1;
            else ground_short_b_det <= 1;
            cyc(3);
            ground_short_a_det <= 0;
            ground_short_b_det <= 0;
            cyc(12);
            rdst();
            `CHK(power_stage_enable, 1'b0)
            `CHK(rd[28:27], 2'(i + 1))
            if (i == 0) apb(1, `DSF_ADDR_CTRL, 32'h00000000);
            else bridge_enable_n <= 1;
            cyc(5);
            rdst();
            `CHK(rd[28:27], 2'b00)
        end
        bridge_enable_n <= 0;
        apb(1, `DSF_ADDR_CTRL, 32'h00000005);
    endtask

    task automatic t_temp();
        temp_prewarn_det <= 1;
        cyc(5);
        rdst();
        // only named fields are compared, reserved bits ignored
        `CHK(rd[31:24], 8'h84)
        `CHK(power_stage_enable, 1'b1)
        temp_limit_det <= 1;
        cyc(5);
        `CHK(power_stage_enable, 1'b0)
        temp_limit_det <= 0;
        cyc(8);
        rdst();
        `CHK(rd[31:24], 8'h86)
        `CHK(power_stage_enable, 1'b0)
        temp_prewarn_det <= 0;
        cyc(6);
        rdst();
        `CHK(rd[26:25], 2'b00)
        `CHK(power_stage_enable, 1'b1)
    endtask

    task automatic t_misc();
        // open-load read while no fast stepping runs
        open_load_a_det <= 1;
        open_load_b_det <= 1;
        cs_actual <= 5'h13;
        load_measurement_result <= 10'h000;
        cyc(5);
        rdst();
        `CHK(rd[30:29], 2'b11)
        `CHK(power_stage_enable, 1'b1)
        `CHK(rd[`DSF_ST_STALL], 1'b1)
        `CHK(rd[20:16], 5'h13)
        load_measurement_result <= 10'h001;
        load_speed_mode <= 1;
        speed_stall_det <= 1;
        cyc(3);
        rdst();
        `CHK(rd[`DSF_ST_STALL], 1'b1)
        speed_stall_det <= 0;
        cyc(3);
        rdst();
        `CHK(rd[`DSF_ST_STALL], 1'b0)
        keep = rd;
        apb(1, `DSF_ADDR_STATUS, 32'hFFFFFFFF);
        `CHK(err, 1'b0)
        rdst();
        `CHK(rd, keep)
    endtask

    task automatic t_freeze();
        ce <= 0;
        ground_short_a_det <= 1;
        cyc(6);
        ground_short_a_det <= 0;
        cyc(2);
        ce <= 1;
        cyc(6);
        `CHK(power_stage_enable, 1'b1)
        rdst();
        `CHK(rd[28:27], 2'b00)
    endtask

    initial begin
        cyc(10);
        presetn <= 1;
        t_reset();
        t_standstill();
        t_short();
        t_temp();
        t_misc();
        t_freeze();
        tally_and_finish();
    end
endmodule // dsf_driver_status_tb_top

bind dsf_driver_status dsf_driver_status_props #(
    .STANDSTILL_CLOCKS(STANDSTILL_CLOCKS)
) chk_u (
    .pclk, .presetn, .ce, .psel, .penable, .pready, .pslverr,
    .power_stage_enable, .ground_short_a_det, .ground_short_b_det,
    .temp_prewarn_det, .temp_limit_det, .bridge_enable_n
);
`default_nettype wire
